/* File: verif/encoder_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Encoder or thumbwheel: one Gray step per command 1 or 2, both lines flipped by 3, or raw levels loaded
module encoder_model (
  input  wire logic       mclk,
  input  wire logic [1:0] cmd,
  input  wire logic       load,
  input  wire logic [2:0] loadVal,
  output var  logic       inUp,
  output var  logic       inDown,
  output var  logic       inZero
);
  initial {inUp, inDown, inZero} = 3'h0;
  // Code 3 flips both lines at once, a deliberate fault
  always @(posedge mclk) begin
    if (load) {inUp, inDown, inZero} <= loadVal;
    else if (cmd == 2'h1) {inUp, inDown} <= {inDown, ~inUp};
    else if (cmd == 2'h2) {inUp, inDown} <= {~inDown, inUp};
    else if (cmd == 2'h3) {inUp, inDown} <= {~inUp, ~inDown};
  end
endmodule // encoder_model
`default_nettype wire

/* File: verif/quadrature_up_down_counter_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "updown_counter_defs.vh"
module quadrature_up_down_counter_test;
  logic        mclk;
  logic        srst;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [1:0]  cmd;
  logic        load;
  logic [2:0]  loadVal;
  logic [31:0] rdVal;
  wire         waitrequest;
  wire  [31:0] readdata;
  wire         inUp;
  wire         inDown;
  wire         inZero;
  wire         timerUpEvent;
  wire         timerDownEvent;
  wire         boundWarning;
  int          num_errors;
  int          comparisons;
  int          upSeen;
  int          downSeen;
  updown_position_counter updown_position_counter_i (.mclk(mclk), .srst(srst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .waitrequest(waitrequest), .readdata(readdata), .inUp(inUp),
    .inDown(inDown), .inZero(inZero), .timerUpEvent(timerUpEvent),
    .timerDownEvent(timerDownEvent), .boundWarning(boundWarning));
  encoder_model encoder_model_i (.mclk(mclk), .cmd(cmd), .load(load), .loadVal(loadVal),
    .inUp(inUp), .inDown(inDown), .inZero(inZero));
  // System clock, 40 ns
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  // Tally forwarded timer events
  always @(posedge mclk) begin
    if (timerUpEvent === 1'h1) upSeen++;
    if (timerDownEvent === 1'h1) downSeen++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge mclk);
    address <= addr;
    writedata <= data;
    read <= !wr;
    write <= wr;
    @(posedge mclk);
    while (waitrequest !== 1'h0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      results();
    end
    rdVal = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] addr, input logic [31:0] exp);
    bus(1'h0, addr, 32'h0);
    check(rdVal, exp);
  endtask
  // Encoder command or raw load, then settle time
  task automatic move(input logic [1:0] c, input logic ld, input logic [2:0] v, input int n);
    @(posedge mclk);
    cmd <= c;
    load <= ld;
    loadVal <= v;
    @(posedge mclk);
    cmd <= 2'h0;
    load <= 1'h0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {srst, read, write, address, writedata, byteenable} = {3'h4, 4'h0, 32'h0, 4'hF};
    {cmd, load, loadVal} = 6'h00;
    repeat (3) @(posedge mclk);
    srst <= 1'h0;
    rd(`REG_CONFIG, 32'h0);
    rd(`REG_MAXBOUND, `MAXB_RESET);
    rd(`REG_MINBOUND, `MINB_RESET);
    rd(`REG_FILTER, {28'h0, `FILTER_RESET});
    rd(4'hF, 32'h0);
    bus(1'h1, `REG_CONFIG, 32'h1);
    move(2'h1, 1'h0, 3'h0, 2);
    rd(`REG_COUNT, 32'h0);
    repeat (12) @(posedge mclk);
    rd(`REG_COUNT, 32'h1);
    bus(1'h1, `REG_FILTER, 32'h0);
    repeat (4) move(2'h1, 1'h0, 3'h0, 10);
    rd(`REG_COUNT, 32'h5);
    check(upSeen, 32'h5);
    repeat (2) move(2'h2, 1'h0, 3'h0, 10);
    check(downSeen, 32'h2);
    move(2'h3, 1'h0, 3'h0, 10);
    rd(`REG_COUNT, 32'h3);
    rd(`REG_STATUS, 32'h23);
    bus(1'h1, `REG_CONFIG, 32'h3);
    move(2'h0, 1'h1, 3'h4, 10);
    rd(`REG_COUNT, 32'h4);
    bus(1'h1, `REG_CONFIG, 32'h5);
    move(2'h0, 1'h1, 3'h2, 10);
    move(2'h0, 1'h1, 3'h6, 10);
    rd(`REG_COUNT, 32'h3);
    move(2'h0, 1'h1, 3'h0, 10);
    move(2'h0, 1'h1, 3'h4, 10);
    rd(`REG_COUNT, 32'h4);
    bus(1'h1, `REG_CONFIG, 32'h7);
    move(2'h0, 1'h1, 3'h0, 10);
    move(2'h0, 1'h1, 3'h2, 10);
    move(2'h0, 1'h1, 3'h0, 10);
    move(2'h0, 1'h1, 3'h6, 10);
    rd(`REG_COUNT, 32'h3);
    bus(1'h1, `REG_CONFIG, 32'h11);
    bus(1'h1, `REG_STATUS, 32'h7F);
    move(2'h0, 1'h1, 3'h7, 10);
    rd(`REG_COUNT, 32'h0);
    rd(`REG_STATUS, 32'h50);
    bus(1'h1, `REG_STATUS, 32'h7F);
    bus(1'h1, `REG_EVENTMASK, 32'h4);
    bus(1'h1, `REG_MAXBOUND, 32'h2);
    bus(1'h1, `REG_CONFIG, 32'h1);
    repeat (3) move(2'h1, 1'h0, 3'h0, 10);
    check({31'h0, boundWarning}, 32'h1);
    rd(`REG_STATUS, 32'h5);
    bus(1'h1, `REG_STATUS, 32'h4);
    repeat (3) @(posedge mclk);
    check({31'h0, boundWarning}, 32'h0);
    bus(1'h1, `REG_CONFIG, 32'h21);
    bus(1'h1, `REG_COUNT, 32'h0);
    repeat (3) move(2'h1, 1'h0, 3'h0, 10);
    rd(`REG_COUNT, 32'h0);
    bus(1'h1, `REG_CONFIG, 32'h1);
    bus(1'h1, `REG_COUNT, 32'hFFFFFFFF);
    rd(`REG_COUNT, 32'hFFFFFFFF);
    move(2'h1, 1'h0, 3'h0, 10);
    rd(`REG_COUNT, 32'h0);
    results();
  end
endmodule // quadrature_up_down_counter_test
`default_nettype wire

/* File: verif/updown_counter_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the bus handshake and of the event outputs
module updown_counter_checker (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  input wire logic [31:0] readdata,
  input wire logic        inUp,
  input wire logic        inDown,
  input wire logic        inZero,
  input wire logic        timerUpEvent,
  input wire logic        timerDownEvent,
  input wire logic        boundWarning
);
  logic [2:0]  lastIn;
  logic [15:0] quietCnt;
  // Idle time of raw inputs; saturates above the longest filter setting
  always @(posedge mclk) begin
    lastIn <= {inUp, inDown, inZero};
    if (srst || lastIn != {inUp, inDown, inZero}) quietCnt <= 16'h0000;
    else if (quietCnt != 16'hFFFF) quietCnt <= quietCnt + 16'h0001;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  one_wait_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("answer not one cycle after request");
  single_answer_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer held longer than one cycle");
  idle_wait_a: assert property (!(read || write) |-> waitrequest)
    else $error("waitrequest low while idle");
  data_hold_a: assert property (waitrequest && !$past(srst) |-> $stable(readdata))
    else $error("read data moved between answers");
  reset_quiet_a: assert property (disable iff (1'h0) srst |=> waitrequest && readdata == 32'h0
    && !timerUpEvent && !timerDownEvent && !boundWarning)
    else $error("outputs not cleared by reset");
  up_pulse_a: assert property (timerUpEvent |=> !timerUpEvent)
    else $error("up event longer than one cycle");
  dir_excl_a: assert property (!(timerUpEvent && timerDownEvent))
    else $error("both timer events at once");
  event_cause_a: assert property (timerUpEvent || timerDownEvent |-> quietCnt != 16'hFFFF)
    else $error("count event without input activity");
  warn_sticky_a: assert property ($fell(boundWarning) |-> $past(write) || $past(write, 2)
    || $past(write, 3))
    else $error("warning dropped without a write");
  cover property (timerUpEvent);
  cover property (timerDownEvent);
  cover property ($rose(boundWarning));
endmodule // updown_counter_checker
bind updown_position_counter updown_counter_checker updown_counter_checker_i (.mclk(mclk),
  .srst(srst), .read(read), .write(write), .waitrequest(waitrequest), .readdata(readdata),
  .inUp(inUp), .inDown(inDown), .inZero(inZero), .timerUpEvent(timerUpEvent),
  .timerDownEvent(timerDownEvent), .boundWarning(boundWarning));
`default_nettype wire

/* File: verilog/avalon_regs.v */
`timescale 1ns/1ns
`default_nettype none
`include "updown_counter_defs.vh"
// Avalon-MM slave: one wait state, then answer; unmapped reads return zero
module avalon_regs (
  input  wire        mclk,
  input  wire        srst,
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg         waitrequest,
  output reg  [31:0] readdata,
  input  wire [31:0] readValue,
  output reg         wrStrobe,
  output reg  [3:0]  wrAddr,
  output reg  [31:0] wrData,
  output reg  [3:0]  wrBe,
  output reg         rdStrobe,
  output reg  [3:0]  rdAddr
);
  reg busy;

  // First request cycle latches; waitrequest falls one cycle later
  always @(posedge mclk) begin
    if (srst) begin
      busy        <= 1'b0;
      waitrequest <= 1'b1;
      wrStrobe    <= 1'b0;
      rdStrobe    <= 1'b0;
      wrAddr      <= 4'h0;
      wrData   <= 32'h00000000;
      wrBe     <= 4'h0;
      rdAddr   <= 4'h0;
      readdata <= 32'h00000000;
    end else begin
      wrStrobe    <= 1'b0;
      rdStrobe    <= 1'b0;
      waitrequest <= 1'b1;
      if (busy) begin
        busy <= 1'b0;
      end else if (read || write) begin
        busy        <= 1'b1;
        waitrequest <= 1'b0;
        wrStrobe <= write;
        rdStrobe <= read;
        wrAddr   <= address;
        wrData   <= writedata;
        wrBe     <= byteenable;
        rdAddr   <= address;
        // Captured at the take so data already stand at the answer edge
        if (read) begin
          readdata <= readValue;
        end
      end
    end
  end
endmodule // avalon_regs
`default_nettype wire

/* File: verilog/input_debounce.v */
`timescale 1ns/1ns
`default_nettype none
`include "updown_counter_defs.vh"
// Passes a level once it has stayed stable for 2^filterSel + 1 samples
module input_debounce (
  input  wire                      mclk,
  input  wire                      srst,
  input  wire                      rawIn,
  input  wire [`WIDTH_FILTER-1:0]  filterSel,
  output reg                       cleanOut
);
  reg        lastIn;
  reg [15:0] stableCount;
  wire [15:0] limit = (16'h0001 << filterSel) - 16'h0001;

  // Restart the count on any change; filterSel 0 still needs two equal samples
  always @(posedge mclk) begin
    if (srst) begin
      lastIn      <= 1'b0;
      stableCount <= 16'h0000;
      cleanOut    <= 1'b0;
    end else begin
      lastIn <= rawIn;
      if (rawIn != lastIn) begin
        stableCount <= 16'h0000;
      end else if (stableCount >= limit) begin
        cleanOut <= lastIn;
      end else begin
        stableCount <= stableCount + 16'h0001;
      end
    end
  end
endmodule // input_debounce
`default_nettype wire

/* File: verilog/updown_counter_defs.vh */
`ifndef UPDOWN_COUNTER_DEFS_VH
`define UPDOWN_COUNTER_DEFS_VH
// Register word offsets (byte address = 4 * index)
`define REG_CONFIG      4'h0
`define REG_COUNT       4'h1
`define REG_MAXBOUND    4'h2
`define REG_MINBOUND    4'h3
`define REG_STATUS      4'h4
`define REG_FILTER      4'h5
`define REG_EVENTMASK   4'h6
// Configuration fields
`define CFG_ENABLE      0
`define CFG_MODE_LSB    1
`define CFG_MODE_MSB    3
`define CFG_ZERO_CLEARS 4
`define CFG_AUTO_ZERO   5
`define CFG_INVERT_DIR  6
// Counting modes
`define MODE_QUAD       3'h0
`define MODE_BINARY     3'h1
`define MODE_DIRLEVEL   3'h2
`define MODE_DIREDGE    3'h3
// Status bit positions
`define ST_UP           0
`define ST_DOWN         1
`define ST_MAXHIT       2
`define ST_MINHIT       3
`define ST_ZEROMARK     4
`define ST_QERROR       5
`define ST_BUTTON       6
`define ST_WIDTH        7
// Reset values
`define CONFIG_RESET    7'h00
`define FILTER_RESET    4'h3
`define MAXB_RESET      32'h7FFFFFFF
`define MINB_RESET      32'h80000000
`define WIDTH_FILTER    4
`endif

/* File: verilog/updown_position_counter.v */
`timescale 1ns/1ns
`default_nettype none
`include "updown_counter_defs.vh"
// Function
// - 32-bit counter counting up or down
// - Decode input pair as quadrature or binary
// - Direction from level input or edges
// - Third input: zero marker or push-button
// - Programmable debounce on all three inputs
// - Count events forwarded to timer
// - Bound exceed: auto-zero or warning event
module updown_position_counter (
  input  wire        mclk,
  input  wire        srst,
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output wire        waitrequest,
  output wire [31:0] readdata,
  input  wire        inUp,
  input  wire        inDown,
  input  wire        inZero,
  output reg         timerUpEvent,
  output reg         timerDownEvent,
  output reg         boundWarning
);
  reg  [6:0]  ctrlReg;
  reg  [31:0] count;
  reg  [31:0] maxBound;
  reg  [31:0] minBound;
  reg  [`ST_WIDTH-1:0] status;
  reg  [`WIDTH_FILTER-1:0] filterSel;
  reg  [`ST_WIDTH-1:0] eventMask;
  reg  [1:0]  lastPair;
  reg         lastZero;
  reg  [31:0] readValue;
  reg  [31:0] next_count;
  reg  [`ST_WIDTH-1:0] evt;
  wire        cleanUp;
  wire        cleanDown;
  wire        cleanZero;
  wire        wrStrobe;
  wire [3:0]  wrAddr;
  wire [31:0] wrData;
  wire [3:0]  wrBe;
  wire [2:0]  mode = ctrlReg[`CFG_MODE_MSB:`CFG_MODE_LSB];
  wire        enabled = ctrlReg[`CFG_ENABLE];
  wire [1:0]  pair = {cleanUp, cleanDown};
  wire [31:0] cfgMerged;

  // Byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Binary index of a Gray-coded pair
  function [1:0] grayToBin;
    input [1:0] g;
    begin
      grayToBin = {g[1], g[1] ^ g[0]};
    end
  endfunction

  // Byte-lane merge of the configuration word, cut to 7 bits on write
  assign cfgMerged = merge({25'h0000000, ctrlReg}, wrData, wrBe);

  avalon_regs busSlave (
    .mclk        (mclk),
    .srst        (srst),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .waitrequest (waitrequest),
    .readdata    (readdata),
    .readValue   (readValue),
    .wrStrobe    (wrStrobe),
    .wrAddr      (wrAddr),
    .wrData      (wrData),
    .wrBe        (wrBe),
    .rdStrobe    (),
    .rdAddr      ()
  );

  // All three inputs filtered before use
  input_debounce filtUp (
    .mclk      (mclk),
    .srst      (srst),
    .rawIn     (inUp),
    .filterSel (filterSel),
    .cleanOut  (cleanUp)
  );
  input_debounce filtDown (
    .mclk      (mclk),
    .srst      (srst),
    .rawIn     (inDown),
    .filterSel (filterSel),
    .cleanOut  (cleanDown)
  );
  input_debounce filtZero (
    .mclk      (mclk),
    .srst      (srst),
    .rawIn     (inZero),
    .filterSel (filterSel),
    .cleanOut  (cleanZero)
  );

  // Count decode: one step per sample at most
  always @* begin
    next_count = count;
    evt = {`ST_WIDTH{1'b0}};
    if (enabled) begin
      case (mode)
        `MODE_QUAD: begin
          if ((pair ^ lastPair) == 2'b11) begin
            evt[`ST_QERROR] = 1'b1;
          end else if (pair != lastPair) begin
            if (grayToBin(pair) == grayToBin(lastPair) + 2'b01) begin
              evt[`ST_UP] = 1'b1;
            end else begin
              evt[`ST_DOWN] = 1'b1;
            end
          end
        end
        `MODE_BINARY: begin
          // Binary code: +1 or -1 steps only, others ignored
          if (pair == lastPair + 2'b01) begin
            evt[`ST_UP] = 1'b1;
          end else if (pair == lastPair - 2'b01) begin
            evt[`ST_DOWN] = 1'b1;
          end
        end
        `MODE_DIRLEVEL: begin
          // Count on rising edge of first input, direction from second
          if (cleanUp && !lastPair[1]) begin
            if (cleanDown ^ ctrlReg[`CFG_INVERT_DIR]) begin
              evt[`ST_DOWN] = 1'b1;
            end else begin
              evt[`ST_UP] = 1'b1;
            end
          end
        end
        `MODE_DIREDGE: begin
          // Simultaneous edges cancel out
          if (cleanUp && !lastPair[1] && !(cleanDown && !lastPair[0])) begin
            evt[`ST_UP] = 1'b1;
          end else if (cleanDown && !lastPair[0] && !(cleanUp && !lastPair[1])) begin
            evt[`ST_DOWN] = 1'b1;
          end
        end
        default: begin
          next_count = count;
        end
      endcase
      if (evt[`ST_UP]) begin
        next_count = count + 32'h00000001;
      end else if (evt[`ST_DOWN]) begin
        next_count = count - 32'h00000001;
      end
      // Signed bound compare on the new value
      if (evt[`ST_UP] && ($signed(next_count) > $signed(maxBound))) begin
        evt[`ST_MAXHIT] = 1'b1;
      end
      if (evt[`ST_DOWN] && ($signed(next_count) < $signed(minBound))) begin
        evt[`ST_MINHIT] = 1'b1;
      end
      if ((evt[`ST_MAXHIT] || evt[`ST_MINHIT]) && ctrlReg[`CFG_AUTO_ZERO]) begin
        next_count = 32'h00000000;
      end
      if (cleanZero && !lastZero) begin
        evt[`ST_ZEROMARK] = 1'b1;
        evt[`ST_BUTTON] = 1'b1;
        if (ctrlReg[`CFG_ZERO_CLEARS]) begin
          next_count = 32'h00000000;
        end
      end
    end
  end

  // Register file, count and sticky status; hardware set beats clear
  always @(posedge mclk) begin
    if (srst) begin
      ctrlReg        <= `CONFIG_RESET;
      count          <= 32'h00000000;
      maxBound       <= `MAXB_RESET;
      minBound       <= `MINB_RESET;
      status         <= {`ST_WIDTH{1'b0}};
      filterSel      <= `FILTER_RESET;
      eventMask      <= {`ST_WIDTH{1'b0}};
      lastPair       <= 2'b00;
      lastZero       <= 1'b0;
      timerUpEvent   <= 1'b0;
      timerDownEvent <= 1'b0;
      boundWarning   <= 1'b0;
    end else begin
      lastPair <= pair;
      lastZero <= cleanZero;
      count    <= next_count;
      timerUpEvent   <= evt[`ST_UP];
      timerDownEvent <= evt[`ST_DOWN];
      status <= status | evt;
      if (wrStrobe) begin
        case (wrAddr)
          `REG_CONFIG:    ctrlReg <= cfgMerged[6:0];
          `REG_COUNT:     count <= merge(count, wrData, wrBe);
          `REG_MAXBOUND:  maxBound <= merge(maxBound, wrData, wrBe);
          `REG_MINBOUND:  minBound <= merge(minBound, wrData, wrBe);
          `REG_STATUS:    status <= (status & ~wrData[`ST_WIDTH-1:0]) | evt;
          `REG_FILTER:    filterSel <= wrData[`WIDTH_FILTER-1:0];
          `REG_EVENTMASK: eventMask <= wrData[`ST_WIDTH-1:0];
          default:        lastZero <= cleanZero;
        endcase
      end
      // Warning level follows masked bound flags
      boundWarning <= |(eventMask & status &
                        ((`ST_WIDTH'h01 << `ST_MAXHIT) | (`ST_WIDTH'h01 << `ST_MINHIT)));
    end
  end

  // Read mux on the live address, so the take edge can capture it
  always @* begin
    case (address)
      `REG_CONFIG:    readValue = {25'h0000000, ctrlReg};
      `REG_COUNT:     readValue = count;
      `REG_MAXBOUND:  readValue = maxBound;
      `REG_MINBOUND:  readValue = minBound;
      `REG_STATUS:    readValue = {25'h0000000, status};
      `REG_FILTER:    readValue = {28'h0000000, filterSel};
      `REG_EVENTMASK: readValue = {25'h0000000, eventMask};
      default:        readValue = 32'h00000000;
    endcase
  end
endmodule // updown_position_counter
`default_nettype wire
